// ---- inc/sidrf_consts.svh ----
/*
 * constants for the source id / response format register bank:
 * offsets, field positions, reset values and format widths.
 * assumes inclusion by bare name from design and bench files.
 */
`ifndef SIDRF_CONSTS_SVH
`define SIDRF_CONSTS_SVH

`define SIDRF_ADDR_SRC0 8'h1a
`define SIDRF_ADDR_SRC1 8'h1b
`define SIDRF_ADDR_TIMING 8'h22

`define SIDRF_RST_SRC0 8'h00
`define SIDRF_RST_SRC1 8'h00
`define SIDRF_RST_TIMING 8'h00

`define SIDRF_SRC_EN_BIT 7
`define SIDRF_FMT_MSB 6
`define SIDRF_FMT_LSB 4
`define SIDRF_ID_MSB 3
`define SIDRF_ID_LSB 0
`define SIDRF_SRC1_MASK 8'h8f

`define SIDRF_TIM_PER_MSB 7
`define SIDRF_TIM_PER_LSB 5
`define SIDRF_TIM_TRAIN_SEL_BIT 4
`define SIDRF_TIM_CAL_RST_BIT 3
`define SIDRF_TIM_CMD_MSB 2
`define SIDRF_TIM_CMD_LSB 1
`define SIDRF_TIM_CAL_EN_BIT 0

`define SIDRF_PSI5_NARROW 5'h0a
`define SIDRF_PSI5_WIDE 5'h10
`define SIDRF_PSI5_PROG 5'h0a

`endif

// ---- inc/sidrf_pkg.sv ----
/*
 * types for the source id / response format register bank.
 * assumes nothing beyond a systemverilog compiler.
 */
package sidrf_pkg;

	typedef enum logic [2:0] {
		SIDRF_MODE_DSI3 = 3'h0,
		SIDRF_MODE_SPI = 3'h1,
		SIDRF_MODE_I2C = 3'h2,
		SIDRF_MODE_PSI5_ASYNC = 3'h3,
		SIDRF_MODE_PSI5_SYNC = 3'h4,
		SIDRF_MODE_PSI5_DAISY = 3'h5,
		SIDRF_MODE_PSI5_PROG = 3'h6
	} sidrf_mode_t;

	typedef enum logic [1:0] {
		SIDRF_SPI_NONE = 2'h0,
		SIDRF_SPI_SLOT0 = 2'h1,
		SIDRF_SPI_SLOT1 = 2'h2,
		SIDRF_SPI_ERROR = 2'h3
	} sidrf_spi_resp_t;

endpackage

// ---- src/sidrf_bank.sv ----
/*
 * source id / response format / timing configuration register bank.
 * holds both source registers and the timing register, decodes frame
 * layout per protocol mode, resolves spi source id requests and
 * tells the transmitter which slots to send.
 * assumes: one clock, synchronous reset, a protocol front end that
 * issues one-cycle register strobes and spi requests, and an otp loader
 * that presents load values with a one-cycle load strobe after reset.
 */
// Behaviour
// R1: both source registers readable and writable in dsi3, spi, i2c, psi5 prog
// R2: source register contents feed the configuration array error check
// R3: source zero: enable, format, id; source one: enable, reserved, id
// R4: each enable gates its source's responses per protocol
// R5: dsi3 format codes 0..3 give listed id/counter/status/data widths
// R6: dsi3 format codes 4..7 give listed widths and total lengths
// R7: psi5 data width 10 if format msb clear, else 16
// R8: psi5 programming mode always uses a 10-bit data field
// R9: host must not pick a width that cannot fit its timing
// R10: format code has no effect in spi and i2c modes
// R11: spi request: exclusive enabled match selects slot zero or one
// R12: spi request matching both enabled sources returns error response
// R13: spi request matching no enabled source returns error response
// R14: dsi3 periodic: enabled sources send id and slot at own start
// R15: psi5 async/daisy send slot zero always; sync follows enables
// R16: psi5 ignores stored identifiers, only enables count
// R17: timing register: period, train select, cal reset, cmd period, cal en
// R18: timing register readable and writable in the listed modes
// R19: timing register contents feed the configuration array error check
// R20: cal enable trains; else cal reset restores untrained, clear holds
// R21: reserved bits of source one read zero, writes ignored
`timescale 1ns/1ps
`default_nettype none
`include "sidrf_consts.svh"

module sidrf_bank (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire sidrf_pkg::sidrf_mode_t mode_i,
	input wire logic otp_load_i,
	input wire logic [7:0] otp_src0_i,
	input wire logic [7:0] otp_src1_i,
	input wire logic [7:0] otp_timing_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_ack_o,
	output logic reg_err_o,
	input wire logic spi_req_i,
	input wire logic [3:0] spi_source_id_i,
	output sidrf_pkg::sidrf_spi_resp_t spi_resp_o,
	output logic spi_resp_valid_o,
	output logic [2:0] frame_format_code_o,
	output logic [2:0] src_id_bits_o,
	output logic [1:0] keepalive_bits_o,
	output logic [2:0] status_bits_o,
	output logic [4:0] data_bits_o,
	output logic [5:0] frame_total_bits_o,
	output logic send_slot_zero_o,
	output logic send_slot_one_o,
	output logic [3:0] frame_source_id_zero_o,
	output logic [3:0] frame_source_id_one_o,
	output logic [2:0] collection_period_code_o,
	output logic training_protocol_select_o,
	output logic [1:0] command_period_code_o,
	output logic osc_train_o,
	output logic osc_untrained_o,
	output logic osc_hold_o,
	output logic [23:0] cfg_array_o
);

	////////////////////////////////////////////////////////////////////
	// mode decode

	function automatic logic reg_access_ok(sidrf_pkg::sidrf_mode_t m);
		reg_access_ok = (m == sidrf_pkg::SIDRF_MODE_DSI3) ||
			(m == sidrf_pkg::SIDRF_MODE_SPI) ||
			(m == sidrf_pkg::SIDRF_MODE_I2C) ||
			(m == sidrf_pkg::SIDRF_MODE_PSI5_PROG);
	endfunction

	function automatic logic is_psi5(sidrf_pkg::sidrf_mode_t m);
		is_psi5 = (m == sidrf_pkg::SIDRF_MODE_PSI5_ASYNC) ||
			(m == sidrf_pkg::SIDRF_MODE_PSI5_SYNC) ||
			(m == sidrf_pkg::SIDRF_MODE_PSI5_DAISY) ||
			(m == sidrf_pkg::SIDRF_MODE_PSI5_PROG);
	endfunction

	////////////////////////////////////////////////////////////////////
	// register file

	logic [7:0] src0_q, src0_d;
	logic [7:0] src1_q, src1_d;
	logic [7:0] timing_q, timing_d;
	logic [7:0] rdata_q, rdata_d;
	logic ack_q, ack_d;
	logic err_q, err_d;
	logic access_ok;
	logic hit0, hit1, hitt;

	always_comb begin
		access_ok = reg_access_ok(mode_i); // see R1 see R18
		hit0 = reg_addr_i == `SIDRF_ADDR_SRC0;
		hit1 = reg_addr_i == `SIDRF_ADDR_SRC1;
		hitt = reg_addr_i == `SIDRF_ADDR_TIMING;
		src0_d = src0_q;
		src1_d = src1_q;
		timing_d = timing_q;
		rdata_d = rdata_q;
		ack_d = 1'b0;
		err_d = 1'b0;
		if (otp_load_i) begin
			// otp load wins over a bus write in the same cycle
			src0_d = otp_src0_i;
			src1_d = otp_src1_i & `SIDRF_SRC1_MASK; // see R21
			timing_d = otp_timing_i;
		end else if (reg_wr_i && access_ok) begin
			if (hit0) begin
				src0_d = reg_wdata_i; // see R3
			end
			if (hit1) begin
				src1_d = reg_wdata_i & `SIDRF_SRC1_MASK; // see R3 see R21
			end
			if (hitt) begin
				timing_d = reg_wdata_i; // see R17
			end
		end
		if (reg_wr_i || reg_rd_i) begin
			ack_d = 1'b1;
			err_d = !access_ok || !(hit0 || hit1 || hitt);
			if (reg_rd_i) begin
				rdata_d = 8'h00;
				if (access_ok && hit0) begin
					rdata_d = src0_q;
				end else if (access_ok && hit1) begin
					rdata_d = src1_q;
				end else if (access_ok && hitt) begin
					rdata_d = timing_q;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			src0_q <= `SIDRF_RST_SRC0;
			src1_q <= `SIDRF_RST_SRC1;
			timing_q <= `SIDRF_RST_TIMING;
			rdata_q <= 8'h00;
			ack_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			src0_q <= src0_d;
			src1_q <= src1_d;
			timing_q <= timing_d;
			rdata_q <= rdata_d;
			ack_q <= ack_d;
			err_q <= err_d;
		end
	end

	assign reg_rdata_o = rdata_q;
	assign reg_ack_o = ack_q;
	assign reg_err_o = err_q;
	// the error check sees all three registers as one array
	assign cfg_array_o = {timing_q, src1_q, src0_q}; // see R2 see R19

	////////////////////////////////////////////////////////////////////
	// field views

	logic en0, en1;
	logic [2:0] fmt;
	logic [3:0] id0, id1;

	assign en0 = src0_q[`SIDRF_SRC_EN_BIT];
	assign en1 = src1_q[`SIDRF_SRC_EN_BIT];
	assign fmt = src0_q[`SIDRF_FMT_MSB:`SIDRF_FMT_LSB];
	assign id0 = src0_q[`SIDRF_ID_MSB:`SIDRF_ID_LSB];
	assign id1 = src1_q[`SIDRF_ID_MSB:`SIDRF_ID_LSB];
	assign frame_format_code_o = fmt;

	////////////////////////////////////////////////////////////////////
	// frame layout

	logic [2:0] sid_w_d, sid_w_q;
	logic [1:0] ka_w_d, ka_w_q;
	logic [2:0] st_w_d, st_w_q;
	logic [4:0] dat_w_d, dat_w_q;
	logic [5:0] tot_d, tot_q;

	always_comb begin
		sid_w_d = 3'h0;
		ka_w_d = 2'h0;
		st_w_d = 3'h0;
		dat_w_d = 5'h00;
		tot_d = 6'h00;
		if (mode_i == sidrf_pkg::SIDRF_MODE_DSI3) begin
			unique case (fmt)
				3'h0: begin sid_w_d = 3'h0; ka_w_d = 2'h2; st_w_d = 3'h4; // see R5
					dat_w_d = 5'h0a; tot_d = 6'h18; end
				3'h1: begin sid_w_d = 3'h4; ka_w_d = 2'h2; st_w_d = 3'h4; // see R5
					dat_w_d = 5'h0a; tot_d = 6'h1c; end
				3'h2: begin sid_w_d = 3'h0; ka_w_d = 2'h0; st_w_d = 3'h4; // see R5
					dat_w_d = 5'h0c; tot_d = 6'h18; end
				3'h3: begin sid_w_d = 3'h4; ka_w_d = 2'h0; st_w_d = 3'h4; // see R5
					dat_w_d = 5'h0c; tot_d = 6'h1c; end
				3'h4: begin sid_w_d = 3'h0; ka_w_d = 2'h2; st_w_d = 3'h0; // see R6
					dat_w_d = 5'h0a; tot_d = 6'h14; end
				3'h5: begin sid_w_d = 3'h0; ka_w_d = 2'h0; st_w_d = 3'h0; // see R6
					dat_w_d = 5'h10; tot_d = 6'h18; end
				3'h6: begin sid_w_d = 3'h0; ka_w_d = 2'h0; st_w_d = 3'h4; // see R6
					dat_w_d = 5'h10; tot_d = 6'h1c; end
				3'h7: begin sid_w_d = 3'h4; ka_w_d = 2'h0; st_w_d = 3'h4; // see R6
					dat_w_d = 5'h10; tot_d = 6'h20; end
			endcase
		end else if (mode_i == sidrf_pkg::SIDRF_MODE_PSI5_PROG) begin
			dat_w_d = `SIDRF_PSI5_PROG; // see R8
		end else if (is_psi5(mode_i)) begin
			// only the msb counts, lower format bits are don't care
			dat_w_d = fmt[2] ? `SIDRF_PSI5_WIDE : `SIDRF_PSI5_NARROW; // see R7
		end
		// spi and i2c leave every width at zero: format is inert there
		// see R10
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			sid_w_q <= 3'h0;
			ka_w_q <= 2'h0;
			st_w_q <= 3'h0;
			dat_w_q <= 5'h00;
			tot_q <= 6'h00;
		end else begin
			sid_w_q <= sid_w_d;
			ka_w_q <= ka_w_d;
			st_w_q <= st_w_d;
			dat_w_q <= dat_w_d;
			tot_q <= tot_d;
		end
	end

	assign src_id_bits_o = sid_w_q;
	assign keepalive_bits_o = ka_w_q;
	assign status_bits_o = st_w_q;
	assign data_bits_o = dat_w_q;
	assign frame_total_bits_o = tot_q;

	////////////////////////////////////////////////////////////////////
	// slot selection for periodic transmission

	logic snd0_d, snd0_q, snd1_d, snd1_q;
	logic [3:0] fid0_d, fid0_q, fid1_d, fid1_q;

	always_comb begin
		snd0_d = 1'b0;
		snd1_d = 1'b0;
		fid0_d = 4'h0;
		fid1_d = 4'h0;
		unique case (mode_i)
			sidrf_pkg::SIDRF_MODE_DSI3: begin
				snd0_d = en0; // see R4 see R14
				snd1_d = en1; // see R14
				fid0_d = id0;
				fid1_d = id1;
			end
			sidrf_pkg::SIDRF_MODE_PSI5_ASYNC,
			sidrf_pkg::SIDRF_MODE_PSI5_DAISY: begin
				snd0_d = 1'b1; // see R15
			end
			sidrf_pkg::SIDRF_MODE_PSI5_SYNC: begin
				snd0_d = en0; // see R15 see R16
				snd1_d = en1; // see R15
			end
			default: begin
				snd0_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			snd0_q <= 1'b0;
			snd1_q <= 1'b0;
			fid0_q <= 4'h0;
			fid1_q <= 4'h0;
		end else begin
			snd0_q <= snd0_d;
			snd1_q <= snd1_d;
			fid0_q <= fid0_d;
			fid1_q <= fid1_d;
		end
	end

	assign send_slot_zero_o = snd0_q;
	assign send_slot_one_o = snd1_q;
	assign frame_source_id_zero_o = fid0_q;
	assign frame_source_id_one_o = fid1_q;

	////////////////////////////////////////////////////////////////////
	// spi source id resolution

	sidrf_pkg::sidrf_spi_resp_t resp_d, resp_q;
	logic rv_d, rv_q;
	logic m0, m1;

	always_comb begin
		// disabled registers never count as a match
		m0 = en0 && (id0 == spi_source_id_i); // see R4
		m1 = en1 && (id1 == spi_source_id_i);
		rv_d = spi_req_i;
		resp_d = resp_q;
		if (spi_req_i) begin
			if (m0 && !m1) begin
				resp_d = sidrf_pkg::SIDRF_SPI_SLOT0; // see R11
			end else if (m1 && !m0) begin
				resp_d = sidrf_pkg::SIDRF_SPI_SLOT1; // see R11
			end else begin
				resp_d = sidrf_pkg::SIDRF_SPI_ERROR; // see R12 see R13
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			resp_q <= sidrf_pkg::SIDRF_SPI_NONE;
			rv_q <= 1'b0;
		end else begin
			resp_q <= resp_d;
			rv_q <= rv_d;
		end
	end

	assign spi_resp_o = resp_q;
	assign spi_resp_valid_o = rv_q;

	////////////////////////////////////////////////////////////////////
	// timing fields and oscillator training control

	logic cal_en, cal_rst;

	assign cal_en = timing_q[`SIDRF_TIM_CAL_EN_BIT];
	assign cal_rst = timing_q[`SIDRF_TIM_CAL_RST_BIT];
	assign collection_period_code_o =
		timing_q[`SIDRF_TIM_PER_MSB:`SIDRF_TIM_PER_LSB];
	assign training_protocol_select_o = timing_q[`SIDRF_TIM_TRAIN_SEL_BIT];
	assign command_period_code_o =
		timing_q[`SIDRF_TIM_CMD_MSB:`SIDRF_TIM_CMD_LSB];
	assign osc_train_o = cal_en; // see R20
	assign osc_untrained_o = !cal_en && cal_rst; // see R20
	assign osc_hold_o = !cal_en && !cal_rst; // see R20

endmodule

`default_nettype wire

// ---- test/sidrf_bank_checker.sv ----
/* port checker for sidrf_bank.
 assumes a bind from the bench top, one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module sidrf_bank_checker (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire sidrf_pkg::sidrf_mode_t mode_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic reg_ack_o,
	input wire logic spi_req_i,
	input wire logic [3:0] spi_source_id_i,
	input wire sidrf_pkg::sidrf_spi_resp_t spi_resp_o,
	input wire logic spi_resp_valid_o,
	input wire logic [4:0] data_bits_o,
	input wire logic send_slot_zero_o,
	input wire logic send_slot_one_o,
	input wire logic [2:0] collection_period_code_o,
	input wire logic osc_untrained_o,
	input wire logic [23:0] cfg_array_o
);
default clocking @(posedge clk_sys_i); endclocking
default disable iff (srst_i);
logic m0;
logic m1;
logic spi_m;
// matches use register values seen at the request edge
assign m0 = cfg_array_o[7] && cfg_array_o[3:0] == spi_source_id_i;
assign m1 = cfg_array_o[15] && cfg_array_o[11:8] == spi_source_id_i;
assign spi_m = spi_req_i && mode_i == sidrf_pkg::SIDRF_MODE_SPI;
sequence s_req;
	reg_wr_i || reg_rd_i;
endsequence
sequence s_ans;
	reg_ack_o;
endsequence
////////////////////////////////////////////////////////////////////////////
chk_reg_ack_lag: assert property (s_req |=> s_ans)
	else $error("register ack missing");
chk_spi_valid_lag: assert property (spi_req_i |=> spi_resp_valid_o)
	else $error("spi valid missing");
chk_spi_both_err: assert property (spi_m && m0 && m1 |=> spi_resp_o == 2'h3)
	else $error("double match not error");
chk_spi_none_err: assert property (spi_m && !m0 && !m1 |=> spi_resp_o == 2'h3)
	else $error("no match not error");
chk_spi_slot_one: assert property (spi_m && !m0 && m1 |=> spi_resp_o == 2'h2)
	else $error("slot one not chosen");
chk_spi_slot_zero: assert property (spi_m && m0 && !m1 |=>
	spi_resp_o == 2'h1)
	else $error("slot zero not chosen");
chk_psi5_data_width: assert property (mode_i inside {3'h3, 3'h4, 3'h5} |=>
	data_bits_o == ($past(cfg_array_o[6]) ? 5'h10 : 5'h0a))
	else $error("psi5 data width wrong");
chk_prog_data_width: assert property (mode_i == 3'h6 |=> data_bits_o == 5'h0a)
	else $error("prog data width wrong");
chk_async_slot_zero: assert property (mode_i inside {3'h3, 3'h5} |=>
	send_slot_zero_o && !send_slot_one_o)
	else $error("async slots wrong");
chk_src1_reserved_zero: assert property (cfg_array_o[14:12] == 3'h0)
	else $error("reserved bits set");
chk_period_code_field: assert property (collection_period_code_o == cfg_array_o[23:21])
	else $error("period code wrong");
chk_cal_reset_untrained: assert property (!cfg_array_o[16] && cfg_array_o[19] |-> osc_untrained_o)
	else $error("untrained not shown");
endmodule
`default_nettype wire

// ---- test/sidrf_bank_tb_top.sv ----
/* random self-checking bench for sidrf_bank.
 assumes the host model drives strobes and the bench owns mode and otp. */
`timescale 1ns/1ps
`default_nettype none
`include "sidrf_consts.svh"
module sidrf_bank_tb_top;
logic clk_sys_i, srst_i, otp_load_i, reg_wr_i, reg_rd_i, spi_req_i;
logic reg_ack_o, reg_err_o, spi_resp_valid_o, osc_untrained_o;
logic send_slot_zero_o, send_slot_one_o;
logic [7:0] otp_src0_i, otp_src1_i, otp_timing_i, reg_addr_i, reg_wdata_i;
logic [7:0] reg_rdata_o, a, b;
logic [3:0] spi_source_id_i;
logic [2:0] src_id_bits_o, status_bits_o, collection_period_code_o;
logic [2:0] frame_format_code_o;
logic [3:0] frame_source_id_zero_o, frame_source_id_one_o;
logic training_protocol_select_o, osc_train_o, osc_hold_o;
logic [1:0] keepalive_bits_o, command_period_code_o;
logic [4:0] data_bits_o;
logic [5:0] frame_total_bits_o;
logic [23:0] cfg_array_o;
logic [7:0] ad [3] = '{`SIDRF_ADDR_SRC0, `SIDRF_ADDR_SRC1, `SIDRF_ADDR_TIMING};
sidrf_pkg::sidrf_mode_t mode_i;
sidrf_pkg::sidrf_spi_resp_t spi_resp_o;
int errors, checks, seed;
sidrf_bank sidrf_bank_inst (.clk_sys_i, .srst_i, .mode_i, .otp_load_i,
	.otp_src0_i, .otp_src1_i, .otp_timing_i, .reg_wr_i, .reg_rd_i,
	.reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_ack_o, .reg_err_o,
	.spi_req_i, .spi_source_id_i, .spi_resp_o, .spi_resp_valid_o,
	.frame_format_code_o, .src_id_bits_o, .keepalive_bits_o,
	.status_bits_o, .data_bits_o, .frame_total_bits_o, .send_slot_zero_o,
	.send_slot_one_o, .frame_source_id_zero_o, .frame_source_id_one_o,
	.collection_period_code_o, .training_protocol_select_o,
	.command_period_code_o, .osc_train_o, .osc_untrained_o,
	.osc_hold_o, .cfg_array_o);
sidrf_host_model sidrf_host_model_inst (.clk_sys_i, .reg_wr_o(reg_wr_i),
	.reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
	.spi_req_o(spi_req_i), .spi_id_o(spi_source_id_i));
////////////////////////////////////////////////////////////////////////////
initial begin
	clk_sys_i = 1'b0;
	forever #5 clk_sys_i = ~clk_sys_i;
end
task automatic chk(string n, logic [23:0] e, logic [23:0] s);
	checks++;
	if (s !== e) begin
		errors++;
		$display("[ERR] %s expected %h seen %h", n, e, s);
	end
endtask
task automatic test_done;
	$display("checks %0d errors %0d", checks, errors);
	if (errors == 0 && checks > 0)
		$display("[ PASS ]");
	else
		$display("[ FAIL ]");
	$finish;
endtask
function automatic logic [18:0] exp_fmt(logic [2:0] f);
	case (f)
		3'h0: return {3'h0, 2'h2, 3'h4, 5'h0a, 6'h18};
		3'h1: return {3'h4, 2'h2, 3'h4, 5'h0a, 6'h1c};
		3'h2: return {3'h0, 2'h0, 3'h4, 5'h0c, 6'h18};
		3'h3: return {3'h4, 2'h0, 3'h4, 5'h0c, 6'h1c};
		3'h4: return {3'h0, 2'h2, 3'h0, 5'h0a, 6'h14};
		3'h5: return {3'h0, 2'h0, 3'h0, 5'h10, 6'h18};
		3'h6: return {3'h0, 2'h0, 3'h4, 5'h10, 6'h1c};
		default: return {3'h4, 2'h0, 3'h4, 5'h10, 6'h20};
	endcase
endfunction
function automatic logic [1:0] exp_spi(logic [7:0] x, logic [7:0] y,
	logic [3:0] id);
	logic m0;
	logic m1;
	m0 = x[7] && x[3:0] == id;
	m1 = y[7] && y[3:0] == id;
	if (m0 == m1)
		return sidrf_pkg::SIDRF_SPI_ERROR;
	return m0 ? sidrf_pkg::SIDRF_SPI_SLOT0 : sidrf_pkg::SIDRF_SPI_SLOT1;
endfunction
// {train, untrained, hold} from the calibration enable and reset bits
function automatic logic [2:0] exp_osc(logic [7:0] t);
	if (t[0])
		return 3'h4;
	return t[3] ? 3'h2 : 3'h1;
endfunction
initial begin
	#50000 errors++;
	test_done;
end
initial begin
	seed = 32'he6db7313;
	{errors, checks} = 0;
	mode_i = sidrf_pkg::SIDRF_MODE_DSI3;
	{otp_load_i, otp_src0_i, otp_src1_i, otp_timing_i} = 25'h0;
	srst_i = 1'b1;
	repeat (2) @(posedge clk_sys_i);
	#1 srst_i = 1'b0;
	foreach (ad[i]) begin
		sidrf_host_model_inst.acc(1'b0, ad[i], 8'h00);
		chk("reset value", 8'h00, reg_rdata_o);
	end
	sidrf_host_model_inst.acc(1'b0, 8'h40, 8'h00);
	chk("unmapped err", 1'b1, reg_err_o);
	$display("test reset done");
	// otp load: cal reset set with cal enable clear for the decode
	otp_src0_i = $random(seed);
	otp_src1_i = $random(seed);
	otp_timing_i = ($random(seed) & 8'hf6) | 8'h08;
	otp_load_i = 1'b1;
	@(posedge clk_sys_i);
	#1 otp_load_i = 1'b0;
	chk("otp array", {otp_timing_i, otp_src1_i & 8'h8f, otp_src0_i}, cfg_array_o);
	$display("test otp done");
	for (int i = 0; i < 16; i++) begin
		mode_i = sidrf_pkg::sidrf_mode_t'((i % 4 == 3) ? 6 : i % 4);
		a = ad[i % 3];
		b = $random(seed);
		sidrf_host_model_inst.acc(1'b1, a, b);
		sidrf_host_model_inst.acc(1'b0, a, 8'h00);
		chk("readback", {reg_err_o, (a == 8'h1b) ? b & 8'h8f : b}, {1'b0, reg_rdata_o});
	end
	sidrf_host_model_inst.acc(1'b1, `SIDRF_ADDR_SRC0, 8'h5a);
	mode_i = sidrf_pkg::SIDRF_MODE_PSI5_SYNC;
	sidrf_host_model_inst.acc(1'b1, 8'h1a, 8'hff);
	chk("psi5 write err", 1'b1, reg_err_o);
	sidrf_host_model_inst.acc(1'b0, `SIDRF_ADDR_SRC0, 8'h00);
	chk("psi5 read", 9'h100, {reg_err_o, reg_rdata_o});
	mode_i = sidrf_pkg::SIDRF_MODE_DSI3;
	sidrf_host_model_inst.acc(1'b0, `SIDRF_ADDR_SRC0, 8'h00);
	chk("psi5 write kept", 8'h5a, reg_rdata_o);
	$display("test access done");
	for (int f = 0; f < 8; f++) begin
		sidrf_host_model_inst.acc(1'b1, 8'h1a, {1'b1, f[2:0], 4'h5});
		@(posedge clk_sys_i);
		#1 chk("dsi3 widths", exp_fmt(f[2:0]), {src_id_bits_o, keepalive_bits_o, status_bits_o, data_bits_o, frame_total_bits_o});
	end
	// source zero now enabled, format 7, id 5; source one id c
	for (int e = 0; e < 2; e++) begin
		sidrf_host_model_inst.acc(1'b1, `SIDRF_ADDR_SRC1, {e[0], 7'h0c});
		@(posedge clk_sys_i);
		#1 chk("dsi3 slots", {1'b1, e[0], 4'h5, 4'hc, 3'h7},
			{send_slot_zero_o, send_slot_one_o, frame_source_id_zero_o,
			frame_source_id_one_o, frame_format_code_o});
	end
	for (int t = 0; t < 3; t++) begin
		b = (t == 0) ? 8'hb5 : (t == 1) ? 8'h08 : 8'h00;
		sidrf_host_model_inst.acc(1'b1, `SIDRF_ADDR_TIMING, b);
		chk("timing fields", {b[7:5], b[4], b[2:1]},
			{collection_period_code_o, training_protocol_select_o,
			command_period_code_o});
		chk("osc control", exp_osc(b),
			{osc_train_o, osc_untrained_o, osc_hold_o});
	end
	$display("test format done");
	mode_i = sidrf_pkg::SIDRF_MODE_SPI;
	for (int i = 0; i < 24; i++) begin
		a = ($random(seed) & 8'h83) | ((i == 0) ? 8'h80 : 8'h00);
		b = (i == 0) ? a : $random(seed) & 8'h83;
		sidrf_host_model_inst.acc(1'b1, 8'h1a, a);
		sidrf_host_model_inst.acc(1'b1, 8'h1b, b);
		sidrf_host_model_inst.req((i == 0) ? a[3:0] : $random(seed) & 4'h3);
		chk("spi resp", {spi_resp_valid_o, exp_spi(a, b, ~spi_source_id_i)}, {1'b1, spi_resp_o});
	end
	chk("spi widths", 11'h000, {data_bits_o, frame_total_bits_o});
	$display("test spi done");
	for (int k = 0; k < 2; k++) begin
		// slot zero disabled so async and daisy must send it anyway
		mode_i = sidrf_pkg::SIDRF_MODE_PSI5_PROG;
		a = k ? 8'h30 : 8'h40;
		sidrf_host_model_inst.acc(1'b1, `SIDRF_ADDR_SRC0, a);
		sidrf_host_model_inst.acc(1'b1, `SIDRF_ADDR_SRC1, 8'h85);
		for (int m = 3; m < 7; m++) begin
			mode_i = sidrf_pkg::sidrf_mode_t'(m);
			repeat (2) @(posedge clk_sys_i);
			#1 chk("psi5 width",
				(m == 6 || !a[6]) ? 5'h0a : 5'h10, data_bits_o);
			chk("psi5 slots",
				(m == 4) ? 2'h1 : (m == 6) ? 2'h0 : 2'h2,
				{send_slot_zero_o, send_slot_one_o});
		end
	end
	$display("test psi5 done");
	// a reset in mid-run must bring back every reset value
	@(posedge clk_sys_i);
	#1 srst_i = 1'b1;
	repeat (2) @(posedge clk_sys_i);
	#1 srst_i = 1'b0;
	chk("reset array", {`SIDRF_RST_TIMING, `SIDRF_RST_SRC1,
		`SIDRF_RST_SRC0}, cfg_array_o);
	chk("reset osc", 3'h1, {osc_train_o, osc_untrained_o, osc_hold_o});
	sidrf_host_model_inst.acc(1'b0, `SIDRF_ADDR_SRC0, 8'h00);
	chk("reset read", 9'h100, {reg_ack_o, reg_rdata_o});
	$display("test mid reset done");
	test_done;
end
endmodule
bind sidrf_bank sidrf_bank_checker sidrf_bank_checker_inst (.clk_sys_i,
	.srst_i, .mode_i, .reg_wr_i, .reg_rd_i, .reg_ack_o, .spi_req_i,
	.spi_source_id_i, .spi_resp_o, .spi_resp_valid_o, .data_bits_o,
	.send_slot_zero_o, .send_slot_one_o, .collection_period_code_o,
	.osc_untrained_o, .cfg_array_o);
`default_nettype wire

// ---- test/sidrf_host_model.sv ----
/* front end model: one-cycle register strobes and spi requests.
 assumes the answer stands one cycle after the strobe edge. */
`timescale 1ns/1ps
`default_nettype none
module sidrf_host_model (
	input wire logic clk_sys_i,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_addr_o,
	output logic [7:0] reg_wdata_o,
	output logic spi_req_o,
	output logic [3:0] spi_id_o
);
initial begin
	{reg_wr_o, reg_rd_o, spi_req_o} = 3'h0;
	{reg_addr_o, reg_wdata_o, spi_id_o} = 20'h0;
end
// width choices are the caller's to keep within timing
task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
	@(posedge clk_sys_i);
	#1 {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
	@(posedge clk_sys_i);
	// idle lines toggle so stale values cannot pass
	#1 {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'h0, ~a, ~d};
endtask
task automatic req(input logic [3:0] id);
	@(posedge clk_sys_i);
	#1 {spi_req_o, spi_id_o} = {1'b1, id};
	@(posedge clk_sys_i);
	#1 {spi_req_o, spi_id_o} = {1'b0, ~id};
endtask
endmodule
`default_nettype wire
